// ---- design/svsw_pkg.sv ----
package svsw_pkg;

	// Clock rate and preset times
	localparam int CLK_MHZ = 10;
	localparam int RST_PU_US = 10000;
	localparam int RST_NC_US = 200000;
	localparam int WD_PU_US = 16000;
	localparam int WD_NC_US = 64000;
	localparam logic [31:0] RST_PU_CYC_DEF = 32'(RST_PU_US * CLK_MHZ);
	localparam logic [31:0] RST_NC_CYC_DEF = 32'(RST_NC_US * CLK_MHZ);
	localparam logic [31:0] WD_PU_CYC_DEF = 32'(WD_PU_US * CLK_MHZ);
	localparam logic [31:0] WD_NC_CYC_DEF = 32'(WD_NC_US * CLK_MHZ);

	// Register byte offsets
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MASK = 8'h04;
	localparam logic [7:0] ADDR_STATE = 8'h08;
	localparam logic [7:0] ADDR_RST_EXT = 8'h0C;
	localparam logic [7:0] ADDR_WD_EXT = 8'h10;

	// Event bits of status and mask
	localparam int NUM_EVT = 4;
	localparam int EVT_RST_ASSERT = 0;
	localparam int EVT_RST_RELEASE = 1;
	localparam int EVT_WD_EARLY = 2;
	localparam int EVT_WD_LATE = 3;

	// Reset values
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [31:0] RST_EXT_RST = 32'h0000_2710;
	localparam logic [31:0] WD_EXT_RST = 32'h0001_86A0;

	// Timing pin strap encodings
	localparam logic [1:0] PIN_CAP = 2'h0;
	localparam logic [1:0] PIN_PULLUP = 2'h1;
	localparam logic [1:0] PIN_OPEN = 2'h2;

	// Window select encodings {win_sel_b, win_sel_a}
	localparam logic [1:0] WSEL_EIGHTH = 2'h0;
	localparam logic [1:0] WSEL_HALF = 2'h1;
	localparam logic [1:0] WSEL_NOLOW = 2'h2;
	localparam logic [1:0] WSEL_OFF = 2'h3;
	localparam int SHIFT_EIGHTH = 3;
	localparam int SHIFT_HALF = 1;

	typedef enum logic [1:0] {
		SUP_POR,
		SUP_OUT,
		SUP_DELAY,
		SUP_RUN
	} svsw_sup_t;

endpackage

// ---- design/svsw_supervisor.sv ----
`timescale 1ns/1ps
module svsw_supervisor #(
	parameter logic [31:0] RST_PU_CYC = svsw_pkg::RST_PU_CYC_DEF,
	parameter logic [31:0] RST_NC_CYC = svsw_pkg::RST_NC_CYC_DEF,
	parameter logic [31:0] WD_PU_CYC = svsw_pkg::WD_PU_CYC_DEF,
	parameter logic [31:0] WD_NC_CYC = svsw_pkg::WD_NC_CYC_DEF
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic power_on_level,
	input wire logic under_threshold,
	input wire logic over_threshold,
	input wire logic wd_kick_in,
	input wire logic win_sel_a,
	input wire logic win_sel_b,
	input wire logic [1:0] wd_timing_pin,
	input wire logic [1:0] rst_timing_pin,
	output logic sup_rst_n_out,
	output logic sup_rst_n_oe,
	output logic wd_fault_n,
	output logic wd_fault_n_oe,
	output logic irq,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);

	typedef struct packed {
		svsw_pkg::svsw_sup_t sup;
		logic rst_n;
		logic fault_act;
		logic kick_prev;
		logic [3:0] status;
		logic [3:0] mask;
		logic [31:0] rst_ext;
		logic [31:0] wd_ext;
		logic ph_wr;
		logic rd_wait;
		logic [7:0] ph_addr;
		logic [31:0] rdata;
	} svsw_state_t;

	svsw_state_t s_q;
	svsw_state_t s_d;

	logic [31:0] rst_cnt;
	logic [31:0] wd_cnt;
	logic rst_clr;
	logic wd_clr;
	logic rail_ok;
	logic wd_disabled;
	logic kick_fall;
	logic [1:0] wsel;
	logic [31:0] rst_delay;
	logic [31:0] wd_upper;
	logic [31:0] wd_lower;
	logic [32:0] rst_next;
	logic [32:0] wd_next;
	logic rst_done;
	logic wd_late;
	logic [3:0] evt;
	logic [3:0] w1c;
	logic take;

	// Pick a delay from the strap: capacitor value, pull-up preset or open preset
	function automatic logic [31:0] svsw_pick(input logic [1:0] pin, input logic [31:0] ext,
		input logic [31:0] pu, input logic [31:0] nc);
		logic [31:0] v;
		case (pin)
			svsw_pkg::PIN_CAP: v = ext;
			svsw_pkg::PIN_PULLUP: v = pu;
			default: v = nc;
		endcase
		return v;
	endfunction

	// Lower window limit as a fraction of the upper one
	function automatic logic [31:0] svsw_lower(input logic [1:0] sel, input logic [31:0] up);
		logic [31:0] v;
		case (sel)
			svsw_pkg::WSEL_EIGHTH: v = up >> svsw_pkg::SHIFT_EIGHTH;
			svsw_pkg::WSEL_HALF: v = up >> svsw_pkg::SHIFT_HALF;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// Register read decode
	function automatic logic [31:0] svsw_read(input logic [7:0] a, input svsw_state_t s, input logic ok,
		input logic dis);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			svsw_pkg::ADDR_STATUS: v = {28'h0000000, s.status};
			svsw_pkg::ADDR_MASK: v = {28'h0000000, s.mask};
			svsw_pkg::ADDR_STATE: v = {26'h0000000, dis, s.fault_act, s.rst_n, ok, s.sup};
			svsw_pkg::ADDR_RST_EXT: v = s.rst_ext;
			svsw_pkg::ADDR_WD_EXT: v = s.wd_ext;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// Reset delay and fault duration share one timer, the window has its own
	svsw_timer u_rst_tmr (
		.clock(clock),
		.reset(reset),
		.clear(rst_clr),
		.count(rst_cnt)
	);

	svsw_timer u_wd_tmr (
		.clock(clock),
		.reset(reset),
		.clear(wd_clr),
		.count(wd_cnt)
	);

	// Configuration decode from straps and programmed values
	assign rail_ok = power_on_level & ~under_threshold & ~over_threshold;
	assign wsel = {win_sel_b, win_sel_a};
	assign wd_disabled = (wsel == svsw_pkg::WSEL_OFF);
	assign rst_delay = svsw_pick(rst_timing_pin, s_q.rst_ext, RST_PU_CYC, RST_NC_CYC);
	assign wd_upper = svsw_pick(wd_timing_pin, s_q.wd_ext, WD_PU_CYC, WD_NC_CYC);
	assign wd_lower = svsw_lower(wsel, wd_upper);
	assign rst_next = {1'b0, rst_cnt} + 33'h0_0000_0001;
	assign wd_next = {1'b0, wd_cnt} + 33'h0_0000_0001;
	assign rst_done = rst_next >= {1'b0, rst_delay};
	assign wd_late = wd_next >= {1'b0, wd_upper};
	assign kick_fall = s_q.kick_prev & ~wd_kick_in;
	assign take = hsel & htrans[1] & hreadyout;

	// Supervisor sequence, watchdog and register file
	always_comb begin
		s_d = s_q;
		evt = 4'h0;
		w1c = 4'h0;
		s_d.kick_prev = wd_kick_in;
		rst_clr = !(s_q.sup == svsw_pkg::SUP_DELAY || (s_q.sup == svsw_pkg::SUP_RUN && s_q.fault_act));
		wd_clr = !(s_q.sup == svsw_pkg::SUP_RUN && !s_q.fault_act && !wd_disabled);
		case (s_q.sup)
			svsw_pkg::SUP_POR: begin
				s_d.rst_n = 1'b0;
				if (power_on_level) begin
					s_d.sup = svsw_pkg::SUP_OUT;
				end
			end
			svsw_pkg::SUP_OUT: begin
				s_d.rst_n = 1'b0;
				if (!power_on_level) begin
					s_d.sup = svsw_pkg::SUP_POR;
				end else if (rail_ok) begin
					s_d.sup = svsw_pkg::SUP_DELAY;
				end
			end
			svsw_pkg::SUP_DELAY: begin
				if (!power_on_level) begin
					s_d.sup = svsw_pkg::SUP_POR;
				end else if (!rail_ok) begin
					s_d.sup = svsw_pkg::SUP_OUT;
				end else if (rst_done) begin
					s_d.sup = svsw_pkg::SUP_RUN;
					s_d.rst_n = 1'b1;
					evt[svsw_pkg::EVT_RST_RELEASE] = 1'b1;
				end
			end
			svsw_pkg::SUP_RUN: begin
				if (!rail_ok) begin
					s_d.sup = power_on_level ? svsw_pkg::SUP_OUT : svsw_pkg::SUP_POR;
					s_d.rst_n = 1'b0;
					s_d.fault_act = 1'b0;
					evt[svsw_pkg::EVT_RST_ASSERT] = 1'b1;
				end else if (s_q.fault_act) begin
					if (rst_done) begin
						s_d.fault_act = 1'b0;
					end
				end else if (!wd_disabled) begin
					if (kick_fall && wd_cnt < wd_lower) begin
						s_d.fault_act = 1'b1;
						evt[svsw_pkg::EVT_WD_EARLY] = 1'b1;
					end else if (kick_fall) begin
						wd_clr = 1'b1;
					end else if (wd_late) begin
						s_d.fault_act = 1'b1;
						evt[svsw_pkg::EVT_WD_LATE] = 1'b1;
					end
				end
			end
			default: begin
				s_d.sup = svsw_pkg::SUP_POR;
				s_d.rst_n = 1'b0;
				s_d.fault_act = 1'b0;
			end
		endcase

		// Bus data phase: writes land now, reads are fetched during one wait cycle
		if (s_q.ph_wr) begin
			case (s_q.ph_addr)
				svsw_pkg::ADDR_STATUS: w1c = hwdata[3:0];
				svsw_pkg::ADDR_MASK: s_d.mask = hwdata[3:0];
				svsw_pkg::ADDR_RST_EXT: s_d.rst_ext = hwdata;
				svsw_pkg::ADDR_WD_EXT: s_d.wd_ext = hwdata;
				default: w1c = 4'h0;
			endcase
		end
		if (s_q.rd_wait) begin
			s_d.rdata = svsw_read(s_q.ph_addr, s_q, rail_ok, wd_disabled);
		end
		s_d.rd_wait = take & ~hwrite;
		s_d.ph_wr = take & hwrite;
		if (take) begin
			s_d.ph_addr = haddr[7:0];
		end

		// Sticky events: a new event wins over a clear in the same cycle
		s_d.status = (s_q.status & ~w1c) | evt;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_q.sup <= svsw_pkg::SUP_POR;
			s_q.rst_n <= 1'b0;
			s_q.fault_act <= 1'b0;
			s_q.kick_prev <= 1'b0;
			s_q.status <= 4'h0;
			s_q.mask <= svsw_pkg::MASK_RST;
			s_q.rst_ext <= svsw_pkg::RST_EXT_RST;
			s_q.wd_ext <= svsw_pkg::WD_EXT_RST;
			s_q.ph_wr <= 1'b0;
			s_q.rd_wait <= 1'b0;
			s_q.ph_addr <= 8'h00;
			s_q.rdata <= 32'h0000_0000;
		end else begin
			s_q <= s_d;
		end
	end

	// Open-drain pins: drive low when enabled, released otherwise
	assign sup_rst_n_out = 1'b0;
	assign sup_rst_n_oe = ~s_q.rst_n;
	assign wd_fault_n = 1'b0;
	assign wd_fault_n_oe = s_q.rst_n & s_q.fault_act;
	assign irq = |(s_q.status & s_q.mask);
	assign hreadyout = ~s_q.rd_wait;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	chk_rail_out_reset: assert property (!rail_ok |=> sup_rst_n_oe)
		else $error("reset not asserted with rail out of window");
	chk_release_after_delay: assert property ($rose(s_q.rst_n) |-> $past(s_q.sup) == svsw_pkg::SUP_DELAY
		&& $past(rst_done))
		else $error("reset released before delay done");
	chk_por_hold: assert property (!power_on_level |=> !s_q.rst_n ##1 !s_q.rst_n)
		else $error("reset released below power-on level");
	chk_early_kick: assert property ((s_q.sup == svsw_pkg::SUP_RUN && rail_ok && !s_q.fault_act
		&& !wd_disabled && kick_fall && wd_cnt < wd_lower) |=> wd_fault_n_oe)
		else $error("early kick not flagged");
	chk_late_kick: assert property ((s_q.sup == svsw_pkg::SUP_RUN && rail_ok && !s_q.fault_act
		&& !wd_disabled && !kick_fall && wd_late) |=> wd_fault_n_oe && s_q.status[svsw_pkg::EVT_WD_LATE])
		else $error("missing kick not flagged");
	chk_kick_ignored: assert property ((wd_disabled || !s_q.rst_n) && !s_q.fault_act |=> !s_q.fault_act)
		else $error("kick used while ignored");
	chk_fault_length: assert property ($fell(s_q.fault_act) && s_q.rst_n |-> $past(rst_next) >= {1'b0, $past(rst_delay)})
		else $error("fault pulse shorter than reset delay");
	chk_fault_hiz: assert property (!s_q.rst_n |-> !wd_fault_n_oe)
		else $error("fault driven while reset low");
	chk_disable_clear: assert property (wd_disabled |=> wd_cnt == 32'h0000_0000)
		else $error("window runs while disabled");
	chk_ext_delay: assert property (rst_timing_pin == svsw_pkg::PIN_CAP |-> rst_delay == s_q.rst_ext)
		else $error("programmed reset delay not used");
	chk_window_restart: assert property ($rose(s_q.rst_n) || $fell(s_q.fault_act) |-> wd_cnt == 32'h0000_0000)
		else $error("window not restarted");

	// Window restart, fault placement, delay hold and sticky event bits
	chk_kick_restart: assert property ((s_q.sup == svsw_pkg::SUP_RUN && rail_ok && !s_q.fault_act
		&& !wd_disabled && kick_fall && wd_cnt >= wd_lower) |=> wd_cnt == 32'h0000_0000 && !s_q.fault_act)
		else $error("accepted kick did not restart window");
	chk_fault_in_run: assert property (wd_fault_n_oe |-> s_q.sup == svsw_pkg::SUP_RUN)
		else $error("fault driven outside run state");
	chk_fault_holds: assert property (s_q.sup == svsw_pkg::SUP_RUN && s_q.fault_act && rail_ok && !rst_done |=> s_q.fault_act)
		else $error("fault ended before reset delay");
	chk_delay_holds: assert property (s_q.sup == svsw_pkg::SUP_DELAY && !rst_done |=> !s_q.rst_n)
		else $error("reset released during delay");
	chk_rail_back_delay: assert property ((s_q.sup == svsw_pkg::SUP_OUT && rail_ok)
		|=> s_q.sup == svsw_pkg::SUP_DELAY && rst_cnt == 32'h0000_0000)
		else $error("delay not started from zero");
	chk_fault_status: assert property ($rose(wd_fault_n_oe) |-> s_q.status[svsw_pkg::EVT_WD_EARLY] || s_q.status[svsw_pkg::EVT_WD_LATE])
		else $error("fault without violation event");
	chk_release_event: assert property ($rose(s_q.rst_n) |-> s_q.status[svsw_pkg::EVT_RST_RELEASE])
		else $error("release event not recorded");
	chk_window_held: assert property (wd_disabled || s_q.fault_act |=> wd_cnt == 32'h0000_0000)
		else $error("window counted while kicks are ignored");

endmodule

// ---- design/svsw_timer.sv ----
`timescale 1ns/1ps
// Saturating elapsed-cycle counter, cleared synchronously
module svsw_timer (
	input wire logic clock,
	input wire logic reset,
	input wire logic clear,
	output logic [31:0] count
);

	typedef struct packed {
		logic [31:0] cnt;
	} svsw_timer_t;

	svsw_timer_t s_q;
	svsw_timer_t s_d;

	// Count up, hold at the top value
	always_comb begin
		s_d = s_q;
		if (clear) begin
			s_d.cnt = 32'h0000_0000;
		end else if (s_q.cnt != 32'hFFFF_FFFF) begin
			s_d.cnt = s_q.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign count = s_q.cnt;

	chk_timer_clear: assert property (@(posedge clock) disable iff (reset) clear |=> count == 32'h0000_0000)
		else $error("timer did not clear");

endmodule

// ---- tb/supply_supervisor_window_watchdog_tb.sv ----
`timescale 1ns/1ps
module supply_supervisor_window_watchdog_tb;
	logic clock = 1'b0, reset = 1'b1, power_on_level = 1'b1, under_threshold = 1'b0, over_threshold = 1'b0;
	logic win_sel_a = 1'b0, win_sel_b = 1'b0, wd_kick_in, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] wd_timing_pin = svsw_pkg::PIN_PULLUP, rst_timing_pin = svsw_pkg::PIN_PULLUP, htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
	logic sup_rst_n_out, sup_rst_n_oe, wd_fault_n, wd_fault_n_oe, irq, hreadyout, hresp;
	logic [2:0] hsize = 3'h0;
	int n_fail = 0, n_tests = 0, n, t0, cyc = 0;
	int dly [3] = '{20, 30, 12};
	logic [1:0] pin [3] = '{svsw_pkg::PIN_PULLUP, svsw_pkg::PIN_OPEN, svsw_pkg::PIN_CAP};

	// Clock at 10 MHz
	always #50 clock = ~clock;
	// Edge count for measuring spans across bus traffic
	always @(posedge clock) cyc <= cyc + 1;

	svsw_host host (.clock(clock), .wd_kick_in(wd_kick_in));

	svsw_supervisor #(.RST_PU_CYC(32'h14), .RST_NC_CYC(32'h1E), .WD_PU_CYC(32'h28), .WD_NC_CYC(32'h32)) uut (
		.clock(clock), .reset(reset), .power_on_level(power_on_level), .under_threshold(under_threshold),
		.over_threshold(over_threshold), .wd_kick_in(wd_kick_in), .win_sel_a(win_sel_a), .win_sel_b(win_sel_b),
		.wd_timing_pin(wd_timing_pin), .rst_timing_pin(rst_timing_pin), .sup_rst_n_out(sup_rst_n_out),
		.sup_rst_n_oe(sup_rst_n_oe), .wd_fault_n(wd_fault_n), .wd_fault_n_oe(wd_fault_n_oe), .irq(irq),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

	// Compare tasks for words and flags
	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_bit(input string name, input logic exp, input logic got);
		chk_word(name, {31'h0, exp}, {31'h0, got});
	endtask

	// Single AHB transfer; ready is looked at in the low half before each edge
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		logic ok;
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do begin
			@(negedge clock);
			ok = hreadyout;
			@(posedge clock);
		end while (ok !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hsize <= 3'h0;
		do begin
			@(negedge clock);
			ok = hreadyout;
			r = hrdata;
			@(posedge clock);
		end while (ok !== 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, {24'h0, a}, d, rd);
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, {24'h0, a}, 32'h0, rd);
		chk_word(name, exp, rd);
	endtask

	// Counts cycles until the reset (sel 0) or fault (sel 1) enable reaches v
	task automatic wait_on(input int sel, input logic v, output int c);
		c = 0;
		while (((sel == 1) ? wd_fault_n_oe : sup_rst_n_oe) !== v && c < 400) begin
			@(negedge clock);
			c++;
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		#(100 * 6000);
		n_fail++;
		give_verdict();
	end

	initial begin
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		chk_bit("rst_held", 1'b1, sup_rst_n_oe);
		chk_bit("fault_off_in_rst", 1'b0, wd_fault_n_oe);
		chk_bit("rst_pin_low", 1'b0, sup_rst_n_out);
		chk_bit("fault_pin_low", 1'b0, wd_fault_n);
		chk_bit("hresp_okay", 1'b0, hresp);
		wait_on(0, 1'b0, n);
		chk_bit("por_delay", 1'b1, n >= 20 && n <= 24);
		t0 = cyc;
		rd_chk("mask_rst", svsw_pkg::ADDR_MASK, 32'h0);
		rd_chk("rst_ext_rst", svsw_pkg::ADDR_RST_EXT, 32'h0000_2710);
		rd_chk("wd_ext_rst", svsw_pkg::ADDR_WD_EXT, 32'h0001_86A0);
		rd_chk("unmapped", 8'h20, 32'h0);
		wr(svsw_pkg::ADDR_MASK, 32'h0000_000F);
		rd_chk("mask_rw", svsw_pkg::ADDR_MASK, 32'h0000_000F);
		// Missing kick: fault after the upper limit, lasting one reset delay
		wait_on(1, 1'b1, n);
		chk_bit("late_time", 1'b1, cyc - t0 >= 40 && cyc - t0 <= 41);
		t0 = cyc;
		chk_bit("rst_high_in_fault", 1'b0, sup_rst_n_oe);
		chk_bit("irq_late", 1'b1, irq);
		rd_chk("status_late", svsw_pkg::ADDR_STATUS, 32'h0000_000A);
		wait_on(1, 1'b0, n);
		chk_bit("fault_len", 1'b1, cyc - t0 >= 20 && cyc - t0 <= 21);
		wr(svsw_pkg::ADDR_STATUS, 32'h0000_000F);
		@(negedge clock);
		chk_bit("irq_clear", 1'b0, irq);
		// Early kick below the lower limit
		host.kick(1);
		wait_on(1, 1'b1, n);
		chk_bit("early_fault", 1'b1, n <= 6);
		rd_chk("status_early", svsw_pkg::ADDR_STATUS, 32'h0000_0004);
		wait_on(1, 1'b0, n);
		wr(svsw_pkg::ADDR_STATUS, 32'h0000_000F);
		// Kicks inside the window keep the fault away
		repeat (4) host.kick(15);
		chk_bit("no_fault", 1'b0, wd_fault_n_oe);
		rd_chk("status_good", svsw_pkg::ADDR_STATUS, 32'h0);
		// Disabled watchdog ignores missing and early kicks
		win_sel_a <= 1'b1;
		win_sel_b <= 1'b1;
		host.kick(1);
		repeat (100) @(posedge clock);
		chk_bit("dis_no_fault", 1'b0, wd_fault_n_oe);
		xfer(1'b0, {24'h0, svsw_pkg::ADDR_STATE}, 32'h0, rd);
		chk_bit("dis_flag", 1'b1, rd[5]);
		// Over rail asserts reset at once, fault released
		over_threshold <= 1'b1;
		repeat (2) @(negedge clock);
		chk_bit("ov_rst", 1'b1, sup_rst_n_oe);
		chk_bit("ov_fault_off", 1'b0, wd_fault_n_oe);
		rd_chk("status_rail", svsw_pkg::ADDR_STATUS, 32'h0000_0001);
		over_threshold <= 1'b0;
		wait_on(0, 1'b0, n);
		chk_bit("ov_release", 1'b1, n >= 20 && n <= 24);
		// Each reset delay source in turn
		wr(svsw_pkg::ADDR_RST_EXT, 32'h0000_000C);
		foreach (dly[i]) begin
			@(posedge clock);
			rst_timing_pin <= pin[i];
			under_threshold <= 1'b1;
			repeat (3) @(posedge clock);
			chk_bit("uv_rst", 1'b1, sup_rst_n_oe);
			under_threshold <= 1'b0;
			wait_on(0, 1'b0, n);
			chk_bit("delay_src", 1'b1, n >= dly[i] && n <= dly[i] + 4);
		end
		// Dropping below power-on level asserts reset again
		@(posedge clock);
		power_on_level <= 1'b0;
		repeat (3) @(negedge clock);
		chk_bit("por_low", 1'b1, sup_rst_n_oe);
		@(posedge clock);
		power_on_level <= 1'b1;
		wait_on(0, 1'b0, n);
		chk_bit("por_again", 1'b1, n >= 12 && n <= 18);
		// Programmed upper limit with half window: early kick, then missing kick
		wr(svsw_pkg::ADDR_WD_EXT, 32'h0000_0018);
		wd_timing_pin <= svsw_pkg::PIN_CAP;
		win_sel_a <= 1'b1;
		win_sel_b <= 1'b0;
		host.kick(8);
		chk_bit("half_early", 1'b1, wd_fault_n_oe);
		wait_on(1, 1'b0, n);
		wait_on(1, 1'b1, n);
		chk_bit("cap_upper", 1'b1, n >= 24 && n <= 25);
		// Open strap with no lower limit: an immediate kick is taken, upper limit from the preset
		wait_on(1, 1'b0, n);
		@(posedge clock);
		wd_timing_pin <= svsw_pkg::PIN_OPEN;
		win_sel_a <= 1'b0;
		win_sel_b <= 1'b1;
		host.kick(1);
		wait_on(1, 1'b1, n);
		chk_bit("open_upper", 1'b1, n >= 49 && n <= 51);
		give_verdict();
	end
endmodule

// ---- tb/svsw_host.sv ----
`timescale 1ns/1ps
// Host side that services the watchdog with falling edges on request
module svsw_host (
	input wire logic clock,
	output logic wd_kick_in
);
	// Idle level is high, never left floating
	initial wd_kick_in = 1'b1;
	// Falls after n cycles, rises again two cycles later
	task automatic kick(input int n);
		repeat (n) @(posedge clock);
		wd_kick_in <= 1'b0;
		repeat (2) @(posedge clock);
		wd_kick_in <= 1'b1;
	endtask
endmodule
